// [logic/address_break_pkg.sv]
// Purpose: Shared constants for the address break trigger block.
// Assumes: Register index times four is the AHB byte address.
// Notes:   Offsets are register indices, not byte addresses.
package address_break_pkg;

  // ********************************************************
  // Register indices
  // ********************************************************
  localparam logic [15:0] IDX_BREAK_STATUS   = 16'hfe00;
  localparam logic [15:0] IDX_FLAG_CONTROL   = 16'hfe03;
  localparam logic [15:0] IDX_BREAK_ADDR_HI  = 16'hfe09;
  localparam logic [15:0] IDX_BREAK_ADDR_LO  = 16'hfe0a;
  localparam logic [15:0] IDX_BREAK_CONTROL  = 16'hfe0b;
  localparam logic [15:0] IDX_IRQ_STATUS     = 16'hfe0c;
  localparam logic [15:0] IDX_IRQ_MASK       = 16'hfe0d;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int ENABLE_BIT      = 7;
  localparam int ACTIVE_BIT      = 6;
  localparam int WAIT_EXIT_BIT   = 1;
  localparam int CLEAR_EN_BIT    = 7;
  localparam int IRQ_MATCH_BIT   = 0;
  localparam int IRQ_SOFT_BIT    = 1;
  localparam int IRQ_END_BIT     = 2;
  localparam int IRQ_W           = 3;

  // ********************************************************
  // Reset values and vectors
  // ********************************************************
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  localparam logic [15:0] VECTOR_NORMAL  = 16'hfffc;
  localparam logic [15:0] VECTOR_MONITOR = 16'hfefc;

  // True when a byte address hits the given register index
  function automatic logic reg_hit(input logic [31:0] addr,
                                   input logic [15:0] idx);
    reg_hit = (addr[31:18] == 14'h0000) && (addr[17:2] == idx);
  endfunction

endpackage

// [logic/address_break_trigger.sv]
// Purpose: Address break trigger with AHB-Lite register access.
// Assumes: CPU strobes are single-clock signals on i_mclk.
// Notes:   Reads take one wait state, writes none.
`timescale 1ns/1ns
`default_nettype none
module address_break_trigger #(
  parameter logic [7:0] SOFT_INT_OPCODE = 8'h00
) (
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic        i_clk_en,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  input  wire logic [15:0] i_cpu_addr,
  input  wire logic        i_addr_from_pc,
  input  wire logic        i_opcode_fetch,
  input  wire logic        i_return_from_interrupt,
  input  wire logic        i_monitor_mode,
  input  wire logic        i_wait_mode,
  output logic             o_breakpoint_request,
  output logic             o_force_soft_int,
  output logic [7:0]       o_software_interrupt_opcode,
  output logic [15:0]      o_break_vector,
  output logic             o_break_state,
  output logic             o_flag_clear_enable,
  output logic             o_irq
);

  // ********************************************************
  // Bus slave
  // ********************************************************
  logic [31:0]        addr_q;
  logic               wr_pend_q;
  logic               rd_pend_q;
  logic               hreadyout_q;
  logic [31:0]        hrdata_q;
  logic [31:0]        rdata_w;
  logic               take_w;
  logic               wr_w;

  assign take_w = i_hsel && i_htrans[1] && i_hready;
  assign wr_w   = wr_pend_q;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_q      <= 32'h00000000;
      wr_pend_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h00000000;
    end else if (i_clk_en) begin
      wr_pend_q <= take_w && i_hwrite;
      rd_pend_q <= take_w && !i_hwrite;
      if (take_w) begin
        addr_q <= i_haddr;
      end
      // Wait state lets a preceding write land before the read mux
      if (take_w && !i_hwrite) begin
        hreadyout_q <= 1'b0;
      end else if (rd_pend_q) begin
        hreadyout_q <= 1'b1;
        hrdata_q    <= rdata_w;
      end
    end
  end

  assign o_hreadyout = hreadyout_q;
  assign o_hrdata    = hrdata_q;
  assign o_hresp     = 1'b0;

  // ********************************************************
  // Registers
  // ********************************************************
  localparam int IRQ_W = address_break_pkg::IRQ_W;

  logic [7:0]         brk_hi_q;
  logic [7:0]         brk_lo_q;
  logic               enable_q;
  logic               active_q;
  logic               wait_exit_q;
  logic               clear_en_q;
  logic [IRQ_W-1:0]   irq_sts_q;
  logic [IRQ_W-1:0]   irq_mask_q;
  logic               wr_ctl_w;
  logic               sw_break_w;
  logic               match_w;
  logic               break_take_w;
  logic               in_break_q;
  logic               pending_q;
  logic               break_end_w;
  logic [IRQ_W-1:0]   irq_set_w;

  assign wr_ctl_w   = wr_w &&
    address_break_pkg::reg_hit(addr_q, address_break_pkg::IDX_BREAK_CONTROL);
  assign sw_break_w = wr_ctl_w &&
    i_hwdata[address_break_pkg::ACTIVE_BIT];

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      brk_hi_q <= address_break_pkg::RESET_BYTE;
      brk_lo_q <= address_break_pkg::RESET_BYTE;
    end else if (i_clk_en && wr_w) begin
      if (address_break_pkg::reg_hit(addr_q,
                                     address_break_pkg::IDX_BREAK_ADDR_HI)) begin
        brk_hi_q <= i_hwdata[7:0];
      end
      if (address_break_pkg::reg_hit(addr_q,
                                     address_break_pkg::IDX_BREAK_ADDR_LO)) begin
        brk_lo_q <= i_hwdata[7:0];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      enable_q <= 1'b0;
      active_q <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_ctl_w) begin
        enable_q <= i_hwdata[address_break_pkg::ENABLE_BIT];
      end
      // A match in the clearing cycle still sets the flag
      if (match_w || sw_break_w) begin
        active_q <= 1'b1;
      end else if (wr_ctl_w) begin
        active_q <= i_hwdata[address_break_pkg::ACTIVE_BIT];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wait_exit_q <= 1'b0;
      clear_en_q  <= 1'b0;
    end else if (i_clk_en) begin
      if (break_take_w && i_wait_mode) begin
        wait_exit_q <= 1'b1;
      end else if (wr_w && !i_hwdata[address_break_pkg::WAIT_EXIT_BIT] &&
                   address_break_pkg::reg_hit(addr_q,
                     address_break_pkg::IDX_BREAK_STATUS)) begin
        wait_exit_q <= 1'b0;
      end
      if (wr_w && address_break_pkg::reg_hit(addr_q,
                    address_break_pkg::IDX_FLAG_CONTROL)) begin
        clear_en_q <= i_hwdata[address_break_pkg::CLEAR_EN_BIT];
      end
    end
  end

  always_comb begin
    rdata_w = 32'h00000000;
    if (address_break_pkg::reg_hit(addr_q,
          address_break_pkg::IDX_BREAK_ADDR_HI)) begin
      rdata_w[7:0] = brk_hi_q;
    end else if (address_break_pkg::reg_hit(addr_q,
          address_break_pkg::IDX_BREAK_ADDR_LO)) begin
      rdata_w[7:0] = brk_lo_q;
    end else if (address_break_pkg::reg_hit(addr_q,
          address_break_pkg::IDX_BREAK_CONTROL)) begin
      rdata_w[address_break_pkg::ENABLE_BIT] = enable_q;
      rdata_w[address_break_pkg::ACTIVE_BIT] = active_q;
    end else if (address_break_pkg::reg_hit(addr_q,
          address_break_pkg::IDX_BREAK_STATUS)) begin
      rdata_w[address_break_pkg::WAIT_EXIT_BIT] = wait_exit_q;
    end else if (address_break_pkg::reg_hit(addr_q,
          address_break_pkg::IDX_FLAG_CONTROL)) begin
      rdata_w[address_break_pkg::CLEAR_EN_BIT] = clear_en_q;
    end else if (address_break_pkg::reg_hit(addr_q,
          address_break_pkg::IDX_IRQ_STATUS)) begin
      rdata_w[IRQ_W-1:0] = irq_sts_q;
    end else if (address_break_pkg::reg_hit(addr_q,
          address_break_pkg::IDX_IRQ_MASK)) begin
      rdata_w[IRQ_W-1:0] = irq_mask_q;
    end
  end

  // ********************************************************
  // Break sequencing
  // ********************************************************
  break_addr_compare #(
    .ADDR_W            (16)
  ) u_compare (
    .i_cpu_addr        (i_cpu_addr),
    .i_break_addr_high (brk_hi_q),
    .i_break_addr_low  (brk_lo_q),
    .i_enable          (enable_q),
    .i_addr_from_pc    (i_addr_from_pc),
    .o_match           (match_w)
  );

  // Opcode match stops at once; operand or software break waits for
  // the next opcode fetch so the current instruction completes
  assign break_take_w = !in_break_q &&
    ((match_w && i_opcode_fetch) ||
     (pending_q && i_opcode_fetch));
  assign break_end_w  = in_break_q && i_return_from_interrupt;

  logic               break_req_q;
  logic               force_soft_int_q;
  logic [15:0]        vector_q;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      pending_q <= 1'b0;
    end else if (i_clk_en) begin
      if (break_take_w) begin
        pending_q <= 1'b0;
      end else if (!in_break_q &&
                   ((match_w && !i_opcode_fetch) || sw_break_w)) begin
        pending_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      in_break_q       <= 1'b0;
      break_req_q      <= 1'b0;
      force_soft_int_q <= 1'b0;
      vector_q         <= address_break_pkg::VECTOR_NORMAL;
    end else if (i_clk_en) begin
      break_req_q      <= break_take_w;
      force_soft_int_q <= break_take_w;
      vector_q         <= i_monitor_mode ?
                          address_break_pkg::VECTOR_MONITOR :
                          address_break_pkg::VECTOR_NORMAL;
      if (break_take_w) begin
        in_break_q <= 1'b1;
      end else if (break_end_w) begin
        in_break_q <= 1'b0;
      end
    end
  end

  // ********************************************************
  // Interrupt
  // ********************************************************
  logic               irq_q;

  assign irq_set_w = {break_end_w,
                      break_take_w && !match_w,
                      break_take_w && match_w};

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_sts_q  <= '0;
      irq_mask_q <= '0;
      irq_q      <= 1'b0;
    end else if (i_clk_en) begin
      // Set beats write-one-to-clear in the same cycle
      if (wr_w && address_break_pkg::reg_hit(addr_q,
                    address_break_pkg::IDX_IRQ_STATUS)) begin
        irq_sts_q <= (irq_sts_q & ~i_hwdata[IRQ_W-1:0]) | irq_set_w;
      end else begin
        irq_sts_q <= irq_sts_q | irq_set_w;
      end
      if (wr_w && address_break_pkg::reg_hit(addr_q,
                    address_break_pkg::IDX_IRQ_MASK)) begin
        irq_mask_q <= i_hwdata[IRQ_W-1:0];
      end
      irq_q <= |(irq_sts_q & irq_mask_q);
    end
  end

  assign o_breakpoint_request        = break_req_q;
  assign o_force_soft_int            = force_soft_int_q;
  assign o_software_interrupt_opcode = SOFT_INT_OPCODE;
  assign o_break_vector              = vector_q;
  assign o_break_state               = in_break_q;
  assign o_flag_clear_enable         = clear_en_q;
  assign o_irq                       = irq_q;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  sequence s_soft_write;
    i_clk_en && sw_break_w && !in_break_q && !break_take_w;
  endsequence
  sequence s_next_fetch;
    i_clk_en && pending_q && i_opcode_fetch && !in_break_q;
  endsequence

  a_opcode_match_break: assert property ((i_clk_en && match_w &&
    i_opcode_fetch && !in_break_q) |=> o_breakpoint_request && o_break_state)
    else $error("opcode match gave no break request");
  a_pc_only_compare: assert property ((i_clk_en && !i_addr_from_pc &&
    !pending_q) |=> !o_breakpoint_request)
    else $error("non program address caused a break");
  a_opcode_forced: assert property (o_breakpoint_request |->
    o_force_soft_int && o_software_interrupt_opcode == SOFT_INT_OPCODE)
    else $error("break without forced opcode");
  a_vector_select: assert property (i_clk_en |=> o_break_vector ==
    ($past(i_monitor_mode) ? address_break_pkg::VECTOR_MONITOR
                           : address_break_pkg::VECTOR_NORMAL))
    else $error("wrong break vector");
  a_soft_break: assert property (s_soft_write |=> pending_q)
    else $error("software break not held pending");
  a_pending_taken: assert property (s_next_fetch |=>
    o_breakpoint_request && o_force_soft_int)
    else $error("pending break not taken at fetch");
  a_return_ends_break: assert property ((i_clk_en && in_break_q &&
    i_return_from_interrupt) |=> !o_break_state)
    else $error("return did not end break");
  a_enable_gates: assert property ((i_clk_en && !enable_q &&
    !pending_q) |=> !o_breakpoint_request)
    else $error("break while disabled");
  a_active_set: assert property ((i_clk_en && match_w) |=> active_q)
    else $error("match did not set active flag");
  a_addr_reset: assert property (@(posedge i_mclk) disable iff (1'b0)
    !i_nrst |-> brk_hi_q == 8'h00 && brk_lo_q == 8'h00)
    else $error("break address not zero in reset");
  a_operand_defer: assert property ((i_clk_en && match_w &&
    !i_opcode_fetch && !in_break_q) |=> !o_breakpoint_request && pending_q)
    else $error("operand match broke too early");
  a_full_compare: assert property (match_w |->
    i_cpu_addr == {brk_hi_q, brk_lo_q})
    else $error("match on partial address");

endmodule
`default_nettype wire

// [logic/break_addr_compare.sv]
// Purpose: Sixteen-bit comparator of the program address.
// Assumes: Inputs come from logic on the same clock.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/1ns
`default_nettype none
module break_addr_compare #(
  parameter int ADDR_W = 16
) (
  input  wire logic [ADDR_W-1:0]   i_cpu_addr,
  input  wire logic [ADDR_W/2-1:0] i_break_addr_high,
  input  wire logic [ADDR_W/2-1:0] i_break_addr_low,
  input  wire logic                i_enable,
  input  wire logic                i_addr_from_pc,
  output logic                     o_match
);

  // Data accesses never break: only program counter addresses count
  assign o_match = i_enable && i_addr_from_pc &&
                   (i_cpu_addr == {i_break_addr_high,
                                   i_break_addr_low});

endmodule
`default_nettype wire

// [testbench/address_break_trigger_tb_top.sv]
// Purpose: Self-checking bench for the address break trigger.
// Assumes: One bus master on AHB-Lite, CPU side from cpu_side_model.
// Notes:   Bus status is captured on the falling edge, before each sample.
`timescale 1ns/1ns
`default_nettype none
module address_break_trigger_tb_top;
  localparam logic [7:0] SOFT_OP = 8'h5a; // Arbitrary test opcode
  localparam int LIMIT = 6000;
  logic        i_mclk, i_nrst, hsel, hwrite, hrdy, run, dphase, mon;
  logic        rfi, req, fswi, bstate, irq, rdy_n, from_pc, fetch;
  logic        hresp, fce, wmode;
  logic [1:0]  htrans;
  logic [7:0]  sw_op, dly;
  logic [15:0] caddr, spc, daddr, vec, prev_addr, hit_addr, hit_vec;
  logic [31:0] haddr, hwdata, hrdata, rd_n, rd;
  logic        hit_force;
  int          error_cnt, check_count, cycles, hits;

  address_break_trigger #(.SOFT_INT_OPCODE(SOFT_OP)) address_break_trigger_i (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_clk_en(1'b1), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_cpu_addr(caddr), .i_addr_from_pc(from_pc), .i_opcode_fetch(fetch),
    .i_return_from_interrupt(rfi), .i_monitor_mode(mon),
    .i_wait_mode(wmode), .o_breakpoint_request(req),
    .o_force_soft_int(fswi),
    .o_software_interrupt_opcode(sw_op), .o_break_vector(vec),
    .o_break_state(bstate), .o_flag_clear_enable(fce), .o_irq(irq));

  cpu_side_model cpu_side_model_i (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_run(run), .i_start_pc(spc),
    .i_data_phase(dphase), .i_data_addr(daddr), .i_ret_delay(dly),
    .i_breakpoint_request(req), .o_cpu_addr(caddr),
    .o_addr_from_pc(from_pc), .o_opcode_fetch(fetch),
    .o_return_from_interrupt(rfi));

  // ********************************************************
  // Clock, sampling and timeout
  // ********************************************************
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  always @(negedge i_mclk) begin
    rdy_n = hrdy;
    rd_n = hrdata;
  end
  always @(posedge i_mclk) begin
    if (req === 1'b1) begin
      hits++;
      hit_addr = prev_addr;
      hit_vec = vec;
      hit_force = fswi;
    end
    prev_addr = caddr;
    cycles++;
    if (cycles == LIMIT) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ********************************************************
  // Tasks
  // ********************************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic [15:0] idx, input logic wr,
                     input logic [31:0] wd);
    @(posedge i_mclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {14'h0000, idx, 2'b00};
    do @(posedge i_mclk); while (rdy_n !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge i_mclk); while (rdy_n !== 1'b1);
    rd = rd_n;
  endtask
  task automatic rdc(input string what, input logic [15:0] idx,
                     input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0);
    chk(what, exp, rd);
    chk("response", 0, hresp);
  endtask
  task automatic trial(input string name, input logic [15:0] start,
                       input logic m, input logic [7:0] d,
                       input int nexp, input logic [15:0] at);
    int h0;
    h0 = hits;
    mon <= m;
    dly <= d;
    spc <= start;
    @(posedge i_mclk);
    run <= 1'b1;
    repeat (16) @(posedge i_mclk);
    run <= 1'b0;
    repeat (30) @(posedge i_mclk);
    chk("break count", nexp, hits - h0);
    chk("break state", 0, bstate);
    if (nexp > 0) begin
      chk("break address", at, hit_addr);
      chk("vector", m ? address_break_pkg::VECTOR_MONITOR
                      : address_break_pkg::VECTOR_NORMAL, hit_vec);
      chk("force", 1, hit_force);
      chk("opcode", SOFT_OP, sw_op);
    end
    $display("test %s done", name);
  endtask

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    {i_nrst, hsel, hwrite, run, dphase, mon, wmode} = 7'h00;
    {htrans, haddr, hwdata, spc, daddr} = '0;
    {error_cnt, check_count, cycles, hits} = '0;
    dly = 8'h01;
    repeat (8) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rdc("addr high", address_break_pkg::IDX_BREAK_ADDR_HI, 0);
    rdc("addr low", address_break_pkg::IDX_BREAK_ADDR_LO, 0);
    rdc("control", address_break_pkg::IDX_BREAK_CONTROL, 0);
    rdc("unmapped", 16'hfe01, 0);
    bus(address_break_pkg::IDX_BREAK_ADDR_HI, 1'b1, 32'h12);
    bus(address_break_pkg::IDX_BREAK_ADDR_LO, 1'b1, 32'h34);
    rdc("addr high", address_break_pkg::IDX_BREAK_ADDR_HI, 32'h12);
    trial("disabled", 16'h1230, 1'b0, 8'h01, 0, 0);
    bus(address_break_pkg::IDX_BREAK_CONTROL, 1'b1, 32'h80);
    trial("opcode", 16'h1230, 1'b0, 8'h01, 1, 16'h1234);
    rdc("control", address_break_pkg::IDX_BREAK_CONTROL, 32'hc0);
    rdc("irq status", address_break_pkg::IDX_IRQ_STATUS, 32'h5);
    chk("irq masked", 0, irq);
    bus(address_break_pkg::IDX_IRQ_MASK, 1'b1, 32'h7);
    repeat (2) @(posedge i_mclk);
    chk("irq", 1, irq);
    bus(address_break_pkg::IDX_IRQ_STATUS, 1'b1, 32'h7);
    repeat (2) @(posedge i_mclk);
    chk("irq cleared", 0, irq);
    bus(address_break_pkg::IDX_BREAK_CONTROL, 1'b1, 32'h80);
    rdc("control", address_break_pkg::IDX_BREAK_CONTROL, 32'h80);
    bus(address_break_pkg::IDX_BREAK_ADDR_LO, 1'b1, 32'h35);
    dphase <= 1'b1;
    daddr <= 16'h1235;
    trial("data access", 16'h1230, 1'b0, 8'h01, 0, 0);
    dphase <= 1'b0;
    trial("operand", 16'h1230, 1'b1, 8'h14, 1, 16'h1236);
    bus(address_break_pkg::IDX_BREAK_CONTROL, 1'b1, 32'h80);
    bus(address_break_pkg::IDX_BREAK_ADDR_HI, 1'b1, 32'h13);
    trial("high byte", 16'h1230, 1'b0, 8'h01, 0, 0);
    trial("high match", 16'h1330, 1'b0, 8'h01, 1, 16'h1336);
    bus(address_break_pkg::IDX_IRQ_STATUS, 1'b1, 32'h7);
    bus(address_break_pkg::IDX_BREAK_CONTROL, 1'b1, 32'h40);
    wmode <= 1'b1;
    trial("software", 16'h2000, 1'b0, 8'h03, 1, 16'h2000);
    wmode <= 1'b0;
    rdc("irq status", address_break_pkg::IDX_IRQ_STATUS, 32'h6);
    rdc("wait exit", address_break_pkg::IDX_BREAK_STATUS, 32'h2);
    bus(address_break_pkg::IDX_BREAK_STATUS, 1'b1, 32'h0);
    rdc("wait exit", address_break_pkg::IDX_BREAK_STATUS, 32'h0);
    bus(address_break_pkg::IDX_FLAG_CONTROL, 1'b1, 32'h80);
    rdc("clear enable", address_break_pkg::IDX_FLAG_CONTROL, 32'h80);
    chk("clear enable pin", 1, fce);
    wrap_up();
  end
endmodule
`default_nettype wire

// [testbench/cpu_side_model.sv]
// Purpose: CPU core and integration unit stand-in for the break block.
// Assumes: One clock; break requests arrive as one-cycle pulses.
// Notes:   Even PC values are opcode fetches, odd ones operands or data.
`timescale 1ns/1ns
`default_nettype none
module cpu_side_model (
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic        i_run,
  input  wire logic [15:0] i_start_pc,
  input  wire logic        i_data_phase,
  input  wire logic [15:0] i_data_addr,
  input  wire logic [7:0]  i_ret_delay,
  input  wire logic        i_breakpoint_request,
  output logic [15:0]      o_cpu_addr,
  output logic             o_addr_from_pc,
  output logic             o_opcode_fetch,
  output logic             o_return_from_interrupt
);
  logic [15:0] pc_q;
  logic [7:0]  wait_q;
  logic        run;
  assign run = i_run && (wait_q == 8'h00);
  assign o_opcode_fetch = run && !pc_q[0];
  assign o_addr_from_pc = run && !(i_data_phase && pc_q[0]);
  // Idle bus shows the inverse so a stale address cannot match by luck
  assign o_cpu_addr = !run ? ~pc_q : (o_addr_from_pc ? pc_q : i_data_addr);
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      pc_q <= 16'h0000;
      wait_q <= 8'h00;
      o_return_from_interrupt <= 1'b0;
    end else begin
      o_return_from_interrupt <= (wait_q == 8'h01);
      if (wait_q != 8'h00) begin
        wait_q <= wait_q - 8'h01;
      end else if (i_breakpoint_request) begin
        wait_q <= i_ret_delay;
      end else if (!i_run) begin
        pc_q <= i_start_pc;
      end else begin
        pc_q <= pc_q + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire
